// [sfd_pkg.sv]
// package for the serial flash command decoder: opcodes, counts, frame kinds
// assumes a serial host in clock mode 0, msb first, one data line each way
package sfd_pkg;
    // ------------------------------------------------------------
    // opcodes
    // ------------------------------------------------------------
    localparam logic [7:0] set_write_latch_cmd = 8'h06;
    localparam logic [7:0] clear_write_latch_cmd = 8'h04;
    localparam logic [7:0] read_status_cmd = 8'h05;
    localparam logic [7:0] read_config_cmd = 8'h15;
    localparam logic [7:0] read_ident_cmd = 8'h9F;
    localparam logic [7:0] electronic_id_cmd = 8'hAB;
    localparam logic [7:0] enter_otp_cmd = 8'hB1;
    localparam logic [7:0] leave_otp_cmd = 8'hC1;
    localparam logic [7:0] arm_reset_cmd = 8'h66;
    localparam logic [7:0] do_reset_cmd = 8'h99;
    localparam logic [7:0] write_status_cmd = 8'h01;
    localparam logic [7:0] page_program_cmd = 8'h02;
    localparam logic [7:0] quad_page_program_cmd = 8'h38;
    localparam logic [7:0] sector_erase_cmd = 8'h20;
    localparam logic [7:0] half_block_erase_cmd = 8'h52;
    localparam logic [7:0] block_erase_cmd = 8'hD8;
    localparam logic [7:0] chip_erase_cmd = 8'h60;
    localparam logic [7:0] chip_erase_alt_cmd = 8'hC7;
    // ------------------------------------------------------------
    // counts
    // ------------------------------------------------------------
    localparam logic [2:0] last_bit_of_byte = 3'h7;
    localparam logic [1:0] ident_byte_count = 2'h3;
    localparam logic [4:0] eid_dummy_bits = 5'h18;
    // ------------------------------------------------------------
    // output kinds and frame states
    // ------------------------------------------------------------
    typedef enum {sfd_src_status, sfd_src_config, sfd_src_ident, sfd_src_eid} sfd_src_t;
    typedef enum {sfd_st_idle, sfd_st_opcode, sfd_st_dummy, sfd_st_out, sfd_st_ignore} sfd_state_t;
endpackage

// [sfd_link_if.sv]
// link signals between the pin synchroniser and the command core
// assumes both ends run on the same system clock
`timescale 1ns/1ps
`default_nettype none
interface sfd_link_if;
    logic frame_active;
    logic frame_start;
    logic frame_end;
    logic sck_rise;
    logic sck_fall;
    logic data_in;
    modport sync (output frame_active, frame_start, frame_end, sck_rise, sck_fall, data_in);
    modport core (input frame_active, frame_start, frame_end, sck_rise, sck_fall, data_in);
endinterface
`default_nettype wire

// [sfd_pin_sync.sv]
// pin synchroniser: brings select, serial clock and data into the system clock
// assumes serial clock slow enough to be sampled (at least four system clocks per half)
`timescale 1ns/1ps
`default_nettype none
module sfd_pin_sync (
    input wire logic mclk_i,      // system clock
    input wire logic srst_i,      // sync reset
    input wire logic cs_n_i,      // chip select pin
    input wire logic sclk_i,      // serial clock pin
    input wire logic si_i,        // serial data pin
    sfd_link_if.sync link         // synchronised events
);
    logic [2:0] meta;
    logic [2:0] stable;
    logic [2:0] prev;
    // ------------------------------------------------------------
    // two-stage sync, then one delay for edges
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            meta <= 3'h5;
            stable <= 3'h5;
            prev <= 3'h5;
        end else begin
            meta <= {cs_n_i, sclk_i, si_i};
            stable <= meta;
            prev <= stable;
        end
    end
    // ------------------------------------------------------------
    // events
    // ------------------------------------------------------------
    assign link.frame_active = ~stable[2];
    assign link.frame_start = prev[2] & ~stable[2];
    assign link.frame_end = ~prev[2] & stable[2];
    assign link.sck_rise = ~stable[2] & ~prev[1] & stable[1]; // R21
    assign link.sck_fall = ~stable[2] & prev[1] & ~stable[1];
    assign link.data_in = stable[0];
endmodule
`default_nettype wire

// [sfd_cmd_decoder.sv]
// serial flash command decoder: latch, reset pair, id, status, config, otp mode
// assumes status bits 7..2, config byte and busy come from the array controller
//
// Behaviour
// [R1] reset opcode acts only when arm-reset was the frame just before
// [R2] any other command between arm-reset and reset drops the arm
// [R3] host sends only defined opcodes; unknown ones are ignored here
// [R4] set-write-latch opcode sets the write latch
// [R5] host sets the latch before any program, erase or status write
// [R6] latch commands are one opcode byte framed by select low then high
// [R7] upper io lines are ignored during these commands
// [R8] clear-write-latch opcode clears the write latch
// [R9] latch clears at reset, clear opcode, soft reset and operation completion
// [R10] ident read shifts maker byte then two device bytes, 24 bits
// [R11] raising select during ident output stops the output driver
// [R12] ident opcode not decoded while busy
// [R13] select high after ident returns to standby
// [R14] status read accepted always and repeats while select low
// [R15] host polls busy before new commands during an operation
// [R16] config read accepted always, config byte shifted out
// [R17] enter-otp opcode redirects accesses to the otp region
// [R18] leave-otp opcode returns accesses to the main array
// [R19] electronic id: three dummy bytes then device id byte
// [R20] program and erase opcodes ignored while latch clear
// [R21] msb first on serial input, sampled on serial clock rise
`timescale 1ns/1ps
`default_nettype none
module sfd_cmd_decoder
    import sfd_pkg::*;
#(
    parameter logic [7:0] MAKER_ID = 8'h5A,   // arbitrary value
    parameter logic [7:0] DEVICE_ID_HI = 8'h12, // arbitrary value
    parameter logic [7:0] DEVICE_ID_LO = 8'h34, // arbitrary value
    parameter logic [7:0] ELECTRONIC_ID = 8'h56 // arbitrary value
) (
    input wire logic mclk_i,                 // system clock
    input wire logic srst_i,                 // sync reset, power-up
    input wire logic cs_n_i,                 // chip select pin, active low
    input wire logic sclk_i,                 // serial clock pin
    input wire logic si_i,                   // serial data in pin
    input wire logic [2:0] upper_io_lines_i, // upper data lines, unused
    output logic so_o,                       // serial data out
    output logic so_oe_n_o,                  // low while driving so_o
    input wire logic busy_flag_i,            // program/erase/write running
    input wire logic [5:0] status_hi_i,      // status bits 7..2
    input wire logic [7:0] config_i,         // configuration byte
    input wire logic op_done_i,              // operation finished pulse
    output logic write_latch_o,              // write latch state
    output logic otp_mode_o,                 // accesses go to otp region
    output logic soft_reset_o,               // soft reset pulse
    output logic write_cmd_o,                // accepted write opcode pulse
    output logic [7:0] write_op_o            // opcode of that write
);
    sfd_link_if link ();
    sfd_state_t state;
    sfd_src_t src;
    logic [7:0] op_sr;
    logic [2:0] bit_cnt;
    logic [1:0] byte_idx;
    logic [4:0] dummy_cnt;
    logic [7:0] out_sr;
    logic [7:0] frame_op;
    logic frame_bits_ok;
    logic arm_reset;
    logic write_latch;
    logic otp_mode;

    sfd_pin_sync u_sync (
        .mclk_i(mclk_i),
        .srst_i(srst_i),
        .cs_n_i(cs_n_i),
        .sclk_i(sclk_i),
        .si_i(si_i),
        .link(link)
    );

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic logic is_write_op(input logic [7:0] op);
        return op == write_status_cmd || op == page_program_cmd ||
            op == quad_page_program_cmd || op == sector_erase_cmd ||
            op == half_block_erase_cmd || op == block_erase_cmd ||
            op == chip_erase_cmd || op == chip_erase_alt_cmd;
    endfunction

    function automatic logic [7:0] out_byte(input sfd_src_t s, input logic [1:0] idx,
                                            input logic [7:0] stat, input logic [7:0] cfg);
        logic [7:0] b;
        b = stat;
        unique case (s)
            sfd_src_status: b = stat;
            sfd_src_config: b = cfg;
            sfd_src_eid: b = ELECTRONIC_ID;
            sfd_src_ident: b = (idx == 2'h0) ? MAKER_ID :
                               (idx == 2'h1) ? DEVICE_ID_HI : DEVICE_ID_LO;
        endcase
        return b;
    endfunction

    wire [7:0] next_op = {op_sr[6:0], link.data_in}; // R21 R7
    wire opcode_done = (state == sfd_st_opcode) && link.sck_rise && bit_cnt == last_bit_of_byte;
    wire [7:0] status_byte = {status_hi_i, write_latch, busy_flag_i};
    wire [7:0] cur_byte = out_byte(src, byte_idx, status_byte, config_i);
    // release on the fall after bit 24 so the last bit stands a full serial clock
    wire ident_over = (src == sfd_src_ident) && byte_idx == ident_byte_count &&
                      link.sck_fall; // R10
    // single-byte commands execute at select high after exactly eight bits
    wire exec = link.frame_end && frame_bits_ok; // R6
    wire do_set = exec && frame_op == set_write_latch_cmd; // R4
    wire do_soft_reset = exec && frame_op == do_reset_cmd && arm_reset; // R1
    wire do_clear = (exec && frame_op == clear_write_latch_cmd) || op_done_i ||
                    do_soft_reset; // R8 R9
    wire write_ok = opcode_done && is_write_op(next_op) && write_latch; // R20

    // ------------------------------------------------------------
    // frame state machine
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (srst_i || !link.frame_active) begin
            state <= sfd_st_idle; // R13 R11
            bit_cnt <= 3'h0;
            byte_idx <= 2'h0;
            dummy_cnt <= 5'h00;
            src <= sfd_src_status;
        end else begin
            unique case (state)
                sfd_st_idle: begin
                    state <= sfd_st_opcode;
                end
                sfd_st_opcode: begin
                    if (link.sck_rise) begin
                        bit_cnt <= bit_cnt + 3'h1;
                    end
                    if (opcode_done) begin
                        if (next_op == read_status_cmd) begin
                            state <= sfd_st_out; // R14
                            src <= sfd_src_status;
                        end else if (next_op == read_config_cmd) begin
                            state <= sfd_st_out; // R16
                            src <= sfd_src_config;
                        end else if (next_op == read_ident_cmd && !busy_flag_i) begin
                            state <= sfd_st_out; // R12
                            src <= sfd_src_ident;
                        end else if (next_op == electronic_id_cmd) begin
                            state <= sfd_st_dummy; // R19
                            src <= sfd_src_eid;
                        end else begin
                            state <= sfd_st_ignore; // R3
                        end
                    end
                end
                sfd_st_dummy: begin
                    if (link.sck_rise) begin
                        dummy_cnt <= dummy_cnt + 5'h01;
                        if (dummy_cnt == eid_dummy_bits - 5'h01) begin
                            state <= sfd_st_out; // R19
                        end
                    end
                end
                sfd_st_out: begin
                    if (link.sck_fall) begin
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == last_bit_of_byte && src == sfd_src_ident) begin
                            byte_idx <= byte_idx + 2'h1; // R10
                        end
                    end
                    if (ident_over) begin
                        state <= sfd_st_ignore; // R10
                    end
                end
                sfd_st_ignore: begin
                    state <= sfd_st_ignore;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // opcode shifter and frame bookkeeping
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            op_sr <= 8'h00;
            frame_op <= 8'h00;
            frame_bits_ok <= 1'b0;
        end else if (link.frame_start) begin
            frame_bits_ok <= 1'b0;
        end else if (link.sck_rise) begin
            op_sr <= next_op; // R21
            frame_bits_ok <= opcode_done;
            if (opcode_done) begin
                frame_op <= next_op;
            end
        end
    end

    // ------------------------------------------------------------
    // serial output, changes on serial clock fall
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (srst_i || !link.frame_active || ident_over) begin
            so_o <= 1'b0;
            so_oe_n_o <= 1'b1; // R11
            out_sr <= 8'h00;
        end else if (state == sfd_st_out && link.sck_fall) begin
            so_oe_n_o <= 1'b0;
            if (bit_cnt == 3'h0) begin
                so_o <= cur_byte[7];
                out_sr <= {cur_byte[6:0], 1'b0};
            end else begin
                so_o <= out_sr[7];
                out_sr <= {out_sr[6:0], 1'b0};
            end
        end
    end

    // ------------------------------------------------------------
    // latch, reset arm, otp mode
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            write_latch <= 1'b0; // R9
            arm_reset <= 1'b0;
            otp_mode <= 1'b0;
            soft_reset_o <= 1'b0;
            write_cmd_o <= 1'b0;
            write_op_o <= 8'h00;
        end else begin
            soft_reset_o <= do_soft_reset;
            write_cmd_o <= write_ok; // R20
            if (write_ok) begin
                write_op_o <= next_op;
            end
            if (do_set) begin
                write_latch <= 1'b1; // R4
            end else if (do_clear) begin
                write_latch <= 1'b0; // R9
            end
            if (link.frame_end) begin
                arm_reset <= exec && frame_op == arm_reset_cmd; // R1 R2
            end
            if (do_soft_reset || (exec && frame_op == leave_otp_cmd)) begin
                otp_mode <= 1'b0; // R18
            end else if (exec && frame_op == enter_otp_cmd) begin
                otp_mode <= 1'b1; // R17
            end
        end
    end

    assign write_latch_o = write_latch;
    assign otp_mode_o = otp_mode;
endmodule
`default_nettype wire

// [sfd_cmd_decoder_props.sv]
// checker for the command decoder, on its top ports only
// assumes one clock domain, srst_i synchronous and active high
`timescale 1ns/1ps
`default_nettype none
module sfd_cmd_decoder_chk (
    input wire logic mclk_i, // clock
    input wire logic srst_i, // reset
    input wire logic cs_n_i, // select
    input wire logic op_done_i, // done pulse
    input wire logic so_oe_n_o, // out enable
    input wire logic write_latch_o, // latch
    input wire logic otp_mode_o, // otp mode
    input wire logic soft_reset_o, // soft reset
    input wire logic write_cmd_o, // write pulse
    input wire logic [7:0] write_op_o // write opcode
);
    // cycles since select went high
    logic [3:0] cs_hi_cnt;
    always_ff @(posedge mclk_i) begin
        if (srst_i || !cs_n_i) begin
            cs_hi_cnt <= 4'h0;
        end else if (cs_hi_cnt != 4'hF) begin
            cs_hi_cnt <= cs_hi_cnt + 4'h1;
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    a_reset_clears: assert property ($fell(srst_i) |-> !write_latch_o && !otp_mode_o && so_oe_n_o)
        else $error("outputs not at reset values");
    a_latch_rise: assert property ($rose(write_latch_o) |-> cs_n_i && $past(cs_n_i))
        else $error("latch set inside a frame");
    a_latch_fall: assert property ($fell(write_latch_o) |-> cs_n_i || $past(op_done_i))
        else $error("latch cleared without cause");
    a_done_clears: assert property (op_done_i && cs_hi_cnt > 4'h6 |=> !write_latch_o)
        else $error("latch kept after op done");
    a_write_gated: assert property (write_cmd_o |-> $past(write_latch_o))
        else $error("write accepted with latch clear");
    a_write_pulse: assert property (write_cmd_o |=> !write_cmd_o && $stable(write_op_o))
        else $error("write pulse too long");
    a_soft_reset: assert property (soft_reset_o |->
        cs_n_i ##1 (!soft_reset_o && !write_latch_o && !otp_mode_o))
        else $error("soft reset pulse wrong");
    a_otp_at_cs: assert property ($changed(otp_mode_o) |-> cs_n_i)
        else $error("otp mode changed inside a frame");
    a_oe_release: assert property (cs_n_i [*5] |-> so_oe_n_o)
        else $error("output driven while deselected");
endmodule
bind sfd_cmd_decoder sfd_cmd_decoder_chk i_chk (
    .mclk_i(mclk_i), .srst_i(srst_i), .cs_n_i(cs_n_i), .op_done_i(op_done_i),
    .so_oe_n_o(so_oe_n_o), .write_latch_o(write_latch_o), .otp_mode_o(otp_mode_o),
    .soft_reset_o(soft_reset_o), .write_cmd_o(write_cmd_o), .write_op_o(write_op_o));
`default_nettype wire

// [sfd_host_model.sv]
// host serial controller model: frames, shifts msb first, samples late in sclk high
// assumes mode 0, sclk period of ten system clocks, one task caller at a time
`timescale 1ns/1ps
`default_nettype none
module sfd_host_model (
    input wire logic mclk_i, // system clock
    input wire logic so_i, // data from device
    output logic cs_n_o, // chip select
    output logic sclk_o, // serial clock
    output logic si_o, // data to device
    output logic [2:0] upper_o, // upper io lines
    output logic [7:0] rx_byte_o // byte read back
);
    event rx_ev;
    logic [2:0] upper_cnt = 3'h0;
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        si_o = 1'b0;
        rx_byte_o = 8'h00;
    end
    // lines the device must ignore keep moving
    always @(negedge mclk_i) begin
        upper_cnt <= upper_cnt + 3'h3;
    end
    assign upper_o = upper_cnt;
    task automatic wait_n(input int n);
        repeat (n) @(negedge mclk_i);
    endtask
    task automatic open_frame();
        wait_n(1);
        cs_n_o = 1'b0;
        wait_n(5);
    endtask
    task automatic xfer(input logic [7:0] tx, input logic rd);
        for (int i = 7; i >= 0; i--) begin
            sclk_o = 1'b0;
            si_o = tx[i];
            wait_n(5);
            sclk_o = 1'b1;
            wait_n(4);
            rx_byte_o = {rx_byte_o[6:0], so_i};
            wait_n(1);
        end
        if (rd) ->rx_ev;
    endtask
    task automatic close_frame();
        sclk_o = 1'b0;
        wait_n(5);
        cs_n_o = 1'b1;
        si_o = ~si_o;
        wait_n(10);
    endtask
endmodule
`default_nettype wire

// [sfd_cmd_decoder_tb_top.sv]
// bench for the command decoder: host model frames, read bytes checked off a queue
// assumes package, decoder, checker and host model compiled before
`timescale 1ns/1ps
`default_nettype none
module sfd_cmd_decoder_tb_top;
    import sfd_pkg::*;
    localparam logic [7:0] MAKER = 8'h5A; // arbitrary value
    localparam logic [7:0] DEV_HI = 8'h12; // arbitrary value
    localparam logic [7:0] DEV_LO = 8'h34; // arbitrary value
    localparam logic [7:0] EID = 8'h56; // arbitrary value
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic busy = 1'b0;
    logic done = 1'b0;
    logic oe_seen = 1'b0;
    logic [5:0] st_hi = 6'h00;
    logic [7:0] cfg = 8'h00;
    logic cs_n, sclk, si, so, oe_n, wl, otp, sr, wc;
    logic [2:0] upio;
    logic [7:0] wop, rx;
    logic [7:0] exp_q[$];
    int fails = 0;
    int cmp_count = 0;
    int cyc = 0;
    int rst_cnt = 0;
    int wc_cnt = 0;
    int seed = 32'h8ef11e28;
    wire so_line = oe_n ? ~so : so;
    sfd_cmd_decoder #(.MAKER_ID(MAKER), .DEVICE_ID_HI(DEV_HI), .DEVICE_ID_LO(DEV_LO),
        .ELECTRONIC_ID(EID)) i_dut (
        .mclk_i(mclk), .srst_i(srst), .cs_n_i(cs_n), .sclk_i(sclk), .si_i(si),
        .upper_io_lines_i(upio), .so_o(so), .so_oe_n_o(oe_n), .busy_flag_i(busy),
        .status_hi_i(st_hi), .config_i(cfg), .op_done_i(done), .write_latch_o(wl),
        .otp_mode_o(otp), .soft_reset_o(sr), .write_cmd_o(wc), .write_op_o(wop));
    sfd_host_model i_host (.mclk_i(mclk), .so_i(so_line), .cs_n_o(cs_n), .sclk_o(sclk),
        .si_o(si), .upper_o(upio), .rx_byte_o(rx));
    initial begin
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (sr === 1'b1) rst_cnt++;
        if (wc === 1'b1) wc_cnt++;
        if (oe_n === 1'b0) oe_seen = 1'b1;
        if (cyc == 20000) begin
            fails++;
            $display("wrong value at %0t: timeout", $time);
            finish_test();
        end
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic send(input logic [7:0] op, input int extra, input int nrd);
        i_host.open_frame();
        i_host.xfer(op, 1'b0);
        repeat (extra) i_host.xfer(8'($random(seed)), 1'b0);
        repeat (nrd) i_host.xfer(8'h00, 1'b1);
        i_host.close_frame();
    endtask
    task automatic status_rd(input logic wl_exp);
        st_hi = 6'($random(seed));
        repeat (2) exp_q.push_back({st_hi, wl_exp, busy});
        send(read_status_cmd, 0, 2);
    endtask
    task automatic finish_test();
        $display("checks %0d wrong %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // oldest expected byte against each byte read back
    initial begin
        forever begin
            @(i_host.rx_ev);
            @(posedge mclk);
            check(rx, exp_q.pop_front(), "read byte");
        end
    end
    // ----
    // scenarios
    // ----
    initial begin
        repeat (16) @(negedge mclk);
        srst = 1'b0;
        repeat (4) @(negedge mclk);
        check({6'h00, wl, otp}, 8'h00, "after reset");
        send(set_write_latch_cmd, 0, 0);
        check(8'(wl), 8'h01, "latch set");
        status_rd(1'b1);
        busy = 1'b1;
        status_rd(1'b1);
        cfg = 8'($random(seed));
        repeat (2) exp_q.push_back(cfg);
        send(read_config_cmd, 0, 2);
        oe_seen = 1'b0;
        send(read_ident_cmd, 1, 0);
        check(8'(oe_seen), 8'h00, "ident while busy");
        busy = 1'b0;
        $display("test reads done");
        exp_q.push_back(MAKER);
        exp_q.push_back(DEV_HI);
        exp_q.push_back(DEV_LO);
        send(read_ident_cmd, 0, 3);
        exp_q.push_back(MAKER);
        send(read_ident_cmd, 0, 1);
        status_rd(1'b1);
        exp_q.push_back(EID);
        send(electronic_id_cmd, 3, 1);
        $display("test ident done");
        send(clear_write_latch_cmd, 0, 0);
        check(8'(wl), 8'h00, "latch cleared");
        send(page_program_cmd, 3, 0);
        check(8'(wc_cnt), 8'h00, "write with latch clear");
        send(set_write_latch_cmd, 0, 0);
        send(sector_erase_cmd, 3, 0);
        check(8'(wc_cnt), 8'h01, "write accepted");
        check(wop, sector_erase_cmd, "write opcode");
        @(negedge mclk) done = 1'b1;
        @(negedge mclk) done = 1'b0;
        repeat (2) @(negedge mclk);
        check(8'(wl), 8'h00, "latch after op done");
        $display("test latch done");
        send(enter_otp_cmd, 0, 0);
        check(8'(otp), 8'h01, "otp entered");
        send(leave_otp_cmd, 0, 0);
        check(8'(otp), 8'h00, "otp left");
        send(enter_otp_cmd, 0, 0);
        send(set_write_latch_cmd, 0, 0);
        send(arm_reset_cmd, 0, 0);
        status_rd(1'b1);
        send(do_reset_cmd, 0, 0);
        check(8'(rst_cnt), 8'h00, "reset without arm");
        send(arm_reset_cmd, 0, 0);
        send(do_reset_cmd, 0, 0);
        check(8'(rst_cnt), 8'h01, "armed reset");
        check({6'h00, wl, otp}, 8'h00, "soft reset clears");
        send(set_write_latch_cmd, 0, 0);
        srst = 1'b1;
        repeat (4) @(negedge mclk);
        srst = 1'b0;
        repeat (4) @(negedge mclk);
        check(8'(wl), 8'h00, "latch after reset");
        check(8'(exp_q.size()), 8'h00, "reads outstanding");
        $display("test reset done");
        finish_test();
    end
endmodule
`default_nettype wire
